//--- rtl/load_observer.sv
/*
 * Load observer: models an unloaded motor from the acceleration reference and
 * the position feedback, and estimates load torque, acceleration and velocity.
 * Assumes the parameter port is driven by the fieldbus parameter engine, one
 * access per cycle, and that UPDATE pulses once per control-loop period.
 */
`timescale 1ns/1ps
`default_nettype none
`include "load_observer_regs.svh"

module load_observer #(
  parameter int DW = 32
) (
  input  wire logic                          CLK,
  input  wire logic                          RST,
  input  wire logic                          UPDATE,
  input  wire logic signed [DW-1:0]          ACCEL_REF,
  input  wire logic signed [DW-1:0]          POS_FDBK,
  input  wire logic signed [DW-1:0]          VEL_FDBK,
  input  wire logic [15:0]                   LPF_BW_REQ,
  input  wire logic                          PARAM_WR,
  input  wire logic                          PARAM_RD,
  input  wire logic [9:0]                    PARAM_ID,
  input  wire logic [31:0]                   PARAM_WDATA,
  output logic [31:0]                        PARAM_RDATA,
  output logic                               PARAM_ACK,
  output logic                               PARAM_ERR,
  output logic signed [DW-1:0]               ACCEL_FWD,
  output logic signed [DW-1:0]               VEL_LOOP_FDBK,
  output logic signed [15:0]                 TORQUE_EST,
  output logic                               TORQUE_EST_ACTIVE,
  output logic                               VEL_EST_ACTIVE,
  output logic [15:0]                        LPF_BW_ACTUAL,
  output logic                               LPF_BYPASS,
  output load_observer_pkg::obs_mode_type    MODE_ACTIVE
);

  import load_observer_pkg::*;

  localparam int WW = DW + 16;

  // ==========================================================================
  // Parameter registers
  // ==========================================================================
  obs_mode_type mode_reg, mode_next;
  logic [15:0]  kop_reg, kop_next;
  logic [15:0]  koi_reg, koi_next;
  logic [15:0]  kof_reg, kof_next;
  logic         ovr_reg, ovr_next;
  logic [31:0]  rdata_reg, rdata_next;
  logic         ack_reg, ack_next;
  logic         err_reg, err_next;

  logic signed [DW-1:0] accel_est_reg;
  logic signed [15:0]   torque_est_reg;

  always_comb begin
    mode_next  = mode_reg;
    kop_next   = kop_reg;
    koi_next   = koi_reg;
    kof_next   = kof_reg;
    ovr_next   = ovr_reg;
    rdata_next = rdata_reg;
    ack_next   = PARAM_WR | PARAM_RD;
    err_next   = 1'b0;
    if (PARAM_WR) begin
      unique case (PARAM_ID)
        `PAR_MODE: begin
          // Codes above four are refused so the mode never holds an illegal value.
          if (PARAM_WDATA[31:3] == 29'h0000_0000 && PARAM_WDATA[2:0] <= 3'h4) begin
            mode_next = obs_mode_type'(PARAM_WDATA[2:0]);
          end else begin
            err_next = 1'b1;
          end
        end
        `PAR_KOP: begin
          if (PARAM_WDATA > {16'h0000, `KOP_MAX}) begin
            kop_next = `KOP_MAX;
          end else begin
            kop_next = PARAM_WDATA[15:0];
          end
        end
        `PAR_KOI: begin
          koi_next = PARAM_WDATA[15:0];
        end
        `PAR_KOF: begin
          if (mode_reg != MODE_ACCEL_FB) begin
            err_next = 1'b1;
          end else if (PARAM_WDATA > {16'h0000, `KOF_MAX}) begin
            kof_next = `KOF_MAX;
          end else begin
            kof_next = PARAM_WDATA[15:0];
          end
        end
        `PAR_BW_OVERRIDE: begin
          ovr_next = PARAM_WDATA[0];
        end
        default: begin
          // Estimates are read-only and unknown numbers answer with an error.
          err_next = 1'b1;
        end
      endcase
    end else if (PARAM_RD) begin
      unique case (PARAM_ID)
        `PAR_MODE:        rdata_next = {29'h0000_0000, mode_reg};
        `PAR_KOP:         rdata_next = {16'h0000, kop_reg};
        `PAR_KOI:         rdata_next = {16'h0000, koi_reg};
        `PAR_KOF:         rdata_next = {16'h0000, kof_reg};
        `PAR_BW_OVERRIDE: rdata_next = {31'h0000_0000, ovr_reg};
        `PAR_ACCEL_EST:   rdata_next = 32'(accel_est_reg);
        `PAR_TORQUE_EST:  rdata_next = {{16{torque_est_reg[15]}}, torque_est_reg};
        default: begin
          rdata_next = 32'h0000_0000;
          err_next   = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      mode_reg  <= MODE_OFF;
      kop_reg   <= `KOP_RESET;
      koi_reg   <= `KOI_RESET;
      kof_reg   <= `KOF_RESET;
      ovr_reg   <= `OVERRIDE_RESET;
      rdata_reg <= 32'h0000_0000;
      ack_reg   <= 1'b0;
      err_reg   <= 1'b0;
    end else begin
      mode_reg  <= mode_next;
      kop_reg   <= kop_next;
      koi_reg   <= koi_next;
      kof_reg   <= kof_next;
      ovr_reg   <= ovr_next;
      rdata_reg <= rdata_next;
      ack_reg   <= ack_next;
      err_reg   <= err_next;
    end
  end

  // ==========================================================================
  // Working copies, latched only at an update
  // ==========================================================================
  // Parameters are sampled at UPDATE so a write landing mid-period never mixes
  // old and new gains inside one estimate.
  obs_mode_type amode_reg, amode_next;
  logic [15:0]  akop_reg, akop_next;
  logic [15:0]  akoi_reg, akoi_next;
  logic [15:0]  akof_reg, akof_next;

  always_comb begin
    amode_next = amode_reg;
    akop_next  = akop_reg;
    akoi_next  = akoi_reg;
    akof_next  = akof_reg;
    if (UPDATE) begin
      amode_next = mode_reg;
      akop_next  = kop_reg;
      akoi_next  = koi_reg;
      akof_next  = kof_reg;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      amode_reg <= MODE_OFF;
      akop_reg  <= `KOP_RESET;
      akoi_reg  <= `KOI_RESET;
      akof_reg  <= `KOF_RESET;
    end else begin
      amode_reg <= amode_next;
      akop_reg  <= akop_next;
      akoi_reg  <= akoi_next;
      akof_reg  <= akof_next;
    end
  end

  // ==========================================================================
  // Observer arithmetic
  // ==========================================================================
  // The computation uses the working copies of the previous update, so the new
  // values act from the following period onward.
  logic signed [DW-1:0] pos_prev_reg, pos_prev_next;
  logic signed [DW-1:0] vel_est_reg, vel_est_next;
  logic signed [WW-1:0] integ_reg, integ_next;
  logic signed [DW-1:0] accel_est_next;
  logic signed [15:0]   torque_est_next;

  logic signed [DW-1:0] vel_meas;
  logic signed [DW-1:0] vel_err;
  logic signed [DW-1:0] accel_in;
  logic signed [WW-1:0] fb_gain;
  logic signed [WW-1:0] corr_w;
  logic signed [WW-1:0] integ_step;
  logic signed [WW-1:0] accel_w;
  logic signed [DW-1:0] corr_sat;
  logic signed [DW-1:0] accel_sat;
  logic signed [15:0]   torque_sat;
  logic                 use_integ;

  // Kou: the reference enters the model except in acceleration feedback mode.
  // Kof: unity weighting of the bandwidth term, or the manual gain in mode four.
  always_comb begin
    vel_meas = POS_FDBK - pos_prev_reg;
    vel_err  = vel_meas - vel_est_reg;
    if (amode_reg == MODE_ACCEL_FB) begin
      accel_in = '0;
      fb_gain  = WW'(signed'({1'b0, akop_reg})) * WW'(signed'({1'b0, akof_reg}));
    end else begin
      accel_in = ACCEL_REF;
      fb_gain  = WW'(signed'({1'b0, akop_reg}));
    end
    use_integ  = (amode_reg != MODE_ACCEL_FB);
    integ_step = (WW'(vel_err) * WW'(signed'({1'b0, akoi_reg}))) >>> `GAIN_SHIFT;
    corr_w     = ((WW'(vel_err) * fb_gain) >>> `GAIN_SHIFT) + integ_reg;
    accel_w    = WW'(accel_in) + WW'(corr_sat);
  end

  sat_signed #(.IN_W(WW), .OUT_W(DW)) u_sat_corr (
    .din  (corr_w),
    .dout (corr_sat)
  );

  sat_signed #(.IN_W(WW), .OUT_W(DW)) u_sat_accel (
    .din  (accel_w),
    .dout (accel_sat)
  );

  // The deviation from the unloaded model is the correction term itself.
  sat_signed #(.IN_W(DW), .OUT_W(16)) u_sat_torque (
    .din  (corr_sat),
    .dout (torque_sat)
  );

  always_comb begin
    pos_prev_next   = pos_prev_reg;
    vel_est_next    = vel_est_reg;
    integ_next      = integ_reg;
    accel_est_next  = accel_est_reg;
    torque_est_next = torque_est_reg;
    if (UPDATE) begin
      pos_prev_next = POS_FDBK;
      if (amode_reg == MODE_OFF) begin
        vel_est_next    = POS_FDBK - pos_prev_reg;
        integ_next      = '0;
        accel_est_next  = '0;
        torque_est_next = '0;
      end else begin
        // Integration of the modelled acceleration gives the lag-free velocity.
        vel_est_next    = vel_est_reg + (accel_sat >>> `DT_SHIFT);
        integ_next      = use_integ ? integ_reg + integ_step : '0;
        accel_est_next  = accel_sat;
        torque_est_next = torque_sat;
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pos_prev_reg   <= '0;
      vel_est_reg    <= '0;
      integ_reg      <= '0;
      accel_est_reg  <= '0;
      torque_est_reg <= 16'h0000;
    end else begin
      pos_prev_reg   <= pos_prev_next;
      vel_est_reg    <= vel_est_next;
      integ_reg      <= integ_next;
      accel_est_reg  <= accel_est_next;
      torque_est_reg <= torque_est_next;
    end
  end

  // ==========================================================================
  // Loop outputs
  // ==========================================================================
  logic                 tq_on;
  logic                 vel_on;
  logic signed [DW-1:0] accel_fwd_next;
  logic signed [DW-1:0] vel_out_next;
  logic signed [DW-1:0] accel_fwd_reg;
  logic signed [DW-1:0] vel_out_reg;

  always_comb begin
    tq_on  = 1'b0;
    vel_on = 1'b0;
    unique case (amode_reg)
      MODE_OFF:        begin tq_on = 1'b0; vel_on = 1'b0; end
      MODE_TORQUE:     begin tq_on = 1'b1; vel_on = 1'b0; end
      MODE_TORQUE_VEL: begin tq_on = 1'b1; vel_on = 1'b1; end
      MODE_VEL:        begin tq_on = 1'b0; vel_on = 1'b1; end
      MODE_ACCEL_FB:   begin tq_on = 1'b1; vel_on = 1'b0; end
      default:         begin tq_on = 1'b0; vel_on = 1'b0; end
    endcase
    accel_fwd_next = accel_fwd_reg;
    vel_out_next   = vel_out_reg;
    if (UPDATE) begin
      // Compensation subtracts the estimated load from the forward path.
      accel_fwd_next = tq_on ? ACCEL_REF - corr_sat : ACCEL_REF;
      vel_out_next   = vel_on ? vel_est_reg : VEL_FDBK;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      accel_fwd_reg <= '0;
      vel_out_reg   <= '0;
    end else begin
      accel_fwd_reg <= accel_fwd_next;
      vel_out_reg   <= vel_out_next;
    end
  end

  // ==========================================================================
  // Torque low-pass filter bandwidth limit
  // ==========================================================================
  logic [15:0] lpf_bw_reg, lpf_bw_next;
  logic        bypass_reg, bypass_next;

  always_comb begin
    bypass_next = 1'b0;
    if (!ovr_reg) begin
      if (LPF_BW_REQ == 16'h0000 || LPF_BW_REQ > `LPF_LEGACY_HZ) begin
        lpf_bw_next = `LPF_LEGACY_HZ;
      end else begin
        lpf_bw_next = LPF_BW_REQ;
      end
    end else if (LPF_BW_REQ == 16'h0000) begin
      lpf_bw_next = 16'h0000;
      bypass_next = 1'b1;
    end else if (LPF_BW_REQ > `LPF_OVERRIDE_HZ) begin
      lpf_bw_next = `LPF_OVERRIDE_HZ;
    end else begin
      lpf_bw_next = LPF_BW_REQ;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      lpf_bw_reg <= `LPF_LEGACY_HZ;
      bypass_reg <= 1'b0;
    end else begin
      lpf_bw_reg <= lpf_bw_next;
      bypass_reg <= bypass_next;
    end
  end

  assign PARAM_RDATA       = rdata_reg;
  assign PARAM_ACK         = ack_reg;
  assign PARAM_ERR         = err_reg;
  assign ACCEL_FWD         = accel_fwd_reg;
  assign VEL_LOOP_FDBK     = vel_out_reg;
  assign TORQUE_EST        = torque_est_reg;
  assign TORQUE_EST_ACTIVE = tq_on;
  assign VEL_EST_ACTIVE    = vel_on;
  assign LPF_BW_ACTUAL     = lpf_bw_reg;
  assign LPF_BYPASS        = bypass_reg;
  assign MODE_ACTIVE       = amode_reg;

endmodule

`default_nettype wire

//--- rtl/load_observer_regs.svh
/*
 * Parameter numbers, limits, reset values and scaling for the load observer.
 * Assumes it is included by its bare name by the files that need it.
 */
// Functional notes
// - Mode zero is the reset default; observer idle, no estimates produced.
// - Mode one produces only the torque estimate into the acceleration path.
// - Mode two produces and applies both torque and velocity estimates.
// - Mode three produces only the velocity estimate, replacing measured velocity.
// - Mode four disconnects the acceleration reference; feedback alone drives estimate.
// - Torque estimate is real response deviation from an ideal unloaded motor model.
// - Velocity estimate may be routed to the velocity loop instead of measured velocity.
// - Feedback and input gains set internally; feedback gain writable only in mode four.
// - Observer bandwidth gain is accepted up to 12,500 rad/s.
// - Integral bandwidth gain is a 16-bit unsigned value, 0 to 65,535.
// - Manually written feedback gain is limited to at most 200.
// - Acceleration estimate reads back as 32-bit signed, full range.
// - Torque estimate reads back as 16-bit signed, full range.
// - Override zero: zero request runs 389 Hz, nonzero request capped at 389 Hz.
// - Override one with zero request bypasses the torque low-pass filter.
// - Override one with nonzero request caps the bandwidth at 10,430 Hz.
`ifndef LOAD_OBSERVER_REGS_SVH
`define LOAD_OBSERVER_REGS_SVH

`define PAR_BW_OVERRIDE   10'h041
`define PAR_MODE          10'h1AF
`define PAR_KOP           10'h1B0
`define PAR_KOI           10'h1B1
`define PAR_KOF           10'h1B2
`define PAR_ACCEL_EST     10'h1B3
`define PAR_TORQUE_EST    10'h1B4

`define KOP_MAX           16'h30D4
`define KOF_MAX           16'h00C8
`define LPF_LEGACY_HZ     16'h0185
`define LPF_OVERRIDE_HZ   16'h28BE

`define MODE_RESET        3'h0
`define KOP_RESET         16'h0000
`define KOI_RESET         16'h0000
`define KOF_RESET         16'h0001
`define OVERRIDE_RESET    1'b0

`define GAIN_SHIFT        16
`define DT_SHIFT          4

`endif

//--- rtl/load_observer_pkg.sv
/*
 * Types shared by the load observer design.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package load_observer_pkg;

  typedef enum logic [2:0] {
    MODE_OFF       = 3'b000,
    MODE_TORQUE    = 3'b001,
    MODE_TORQUE_VEL = 3'b010,
    MODE_VEL       = 3'b011,
    MODE_ACCEL_FB  = 3'b100
  } obs_mode_type;

endpackage

//--- rtl/sat_signed.sv
/*
 * Signed saturation from a wide value to a narrower one.
 * Assumes OUT_W is not larger than IN_W.
 */
`timescale 1ns/1ps
`default_nettype none

module sat_signed #(
  parameter int IN_W  = 48,
  parameter int OUT_W = 32
) (
  input  wire logic signed [IN_W-1:0]  din,
  output logic signed [OUT_W-1:0]      dout
);

  localparam logic signed [OUT_W-1:0] MAX_V = {1'b0, {(OUT_W-1){1'b1}}};
  localparam logic signed [OUT_W-1:0] MIN_V = {1'b1, {(OUT_W-1){1'b0}}};

  logic signed [IN_W-1:0] max_w;
  logic signed [IN_W-1:0] min_w;

  assign max_w = IN_W'(MAX_V);
  assign min_w = IN_W'(MIN_V);

  always_comb begin
    if (din > max_w) begin
      dout = MAX_V;
    end else if (din < min_w) begin
      dout = MIN_V;
    end else begin
      dout = din[OUT_W-1:0];
    end
  end

endmodule

`default_nettype wire

//--- tb/load_observer_asserts.sv
/* Port checker for the load observer.
   Assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
`include "load_observer_regs.svh"
module load_observer_asserts
  import load_observer_pkg::*;
#(parameter int DW = 32) (
  input wire logic                  CLK,
  input wire logic                  RST,
  input wire logic                  UPDATE,
  input wire logic signed [DW-1:0]  ACCEL_REF,
  input wire logic signed [DW-1:0]  VEL_FDBK,
  input wire logic [15:0]           LPF_BW_REQ,
  input wire logic                  PARAM_WR,
  input wire logic                  PARAM_RD,
  input wire logic                  PARAM_ACK,
  input wire logic signed [DW-1:0]  ACCEL_FWD,
  input wire logic signed [DW-1:0]  VEL_LOOP_FDBK,
  input wire logic signed [15:0]    TORQUE_EST,
  input wire logic                  TORQUE_EST_ACTIVE,
  input wire logic                  VEL_EST_ACTIVE,
  input wire logic [15:0]           LPF_BW_ACTUAL,
  input wire logic                  LPF_BYPASS,
  input wire obs_mode_type          MODE_ACTIVE
);
  import load_observer_pkg::*;
  // ==========================================================
  // Sequences and assertions
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  sequence s_req; PARAM_WR || PARAM_RD; endsequence
  sequence s_upd_off; UPDATE && MODE_ACTIVE == MODE_OFF; endsequence
  sequence s_upd_no_vel; UPDATE && !VEL_EST_ACTIVE; endsequence
  sequence s_upd_no_trq; UPDATE && !TORQUE_EST_ACTIVE; endsequence

  a_ack_after_req: assert property (s_req |=> PARAM_ACK)
    else $error("no acknowledge after access");
  a_ack_has_cause: assert property (PARAM_ACK |-> $past(PARAM_WR) || $past(PARAM_RD))
    else $error("acknowledge without access");
  a_off_passes: assert property (s_upd_off |=> TORQUE_EST == 0
    && ACCEL_FWD == $past(ACCEL_REF) && VEL_LOOP_FDBK == $past(VEL_FDBK))
    else $error("idle observer altered the loops");
  a_vel_passes: assert property (s_upd_no_vel |=> VEL_LOOP_FDBK == $past(VEL_FDBK))
    else $error("velocity feedback replaced without estimate");
  a_accel_passes: assert property (s_upd_no_trq |=> ACCEL_FWD == $past(ACCEL_REF))
    else $error("acceleration path altered without torque estimate");
  a_trq_modes: assert property (TORQUE_EST_ACTIVE == (MODE_ACTIVE inside
    {MODE_TORQUE, MODE_TORQUE_VEL, MODE_ACCEL_FB}))
    else $error("torque estimate enable wrong for mode");
  a_vel_modes: assert property (VEL_EST_ACTIVE == (MODE_ACTIVE inside
    {MODE_TORQUE_VEL, MODE_VEL}))
    else $error("velocity estimate enable wrong for mode");
  a_outputs_hold: assert property (!UPDATE |=> $stable(TORQUE_EST) && $stable(ACCEL_FWD)
    && $stable(VEL_LOOP_FDBK) && $stable(MODE_ACTIVE))
    else $error("loop outputs changed between updates");
  a_lpf_zero_req: assert property (LPF_BW_REQ == 0 |=> (LPF_BYPASS ?
    LPF_BW_ACTUAL == 0 : LPF_BW_ACTUAL == `LPF_LEGACY_HZ))
    else $error("zero filter request mishandled");
  a_lpf_small_req: assert property (LPF_BW_REQ != 0 && LPF_BW_REQ <= `LPF_LEGACY_HZ
    |=> LPF_BW_ACTUAL == $past(LPF_BW_REQ) && !LPF_BYPASS)
    else $error("small filter request not passed");
  a_lpf_cap: assert property (LPF_BW_REQ > `LPF_OVERRIDE_HZ |=>
    LPF_BW_ACTUAL inside {`LPF_LEGACY_HZ, `LPF_OVERRIDE_HZ})
    else $error("filter request above cap not limited");
endmodule
`default_nettype wire

//--- tb/load_observer_ctl.sv
/* Motion controller model that reads and writes observer parameters.
   Assumes a one-cycle acknowledge pulse one cycle after each access. */
`timescale 1ns/1ps
`default_nettype none
module load_observer_ctl (
  input  wire logic        clk,
  input  wire logic        ack,
  input  wire logic        err,
  input  wire logic [31:0] rdata,
  output logic             wr,
  output logic             rd,
  output logic [9:0]       id,
  output logic [31:0]      wdata
);
  // ==========================================================
  // Parameter access
  initial begin
    wr = 1'b0;
    rd = 1'b0;
    id = 10'h3FF;
    wdata = 32'h0000_0000;
  end
  // Gains go out as separate words, one access per call.
  task automatic access(input logic w, input logic [9:0] pid, input logic [31:0] d,
                        output logic a, output logic e, output logic [31:0] q);
    @(negedge clk);
    wr = w;
    rd = !w;
    id = pid;
    wdata = d;
    @(negedge clk);
    a = ack;
    e = err;
    q = rdata;
    wr = 1'b0;
    rd = 1'b0;
    // Released lines are inverted so no stale value can pass for a live one.
    id = ~pid;
    wdata = ~d;
  endtask
  // Start-up set: mode two, computed bandwidth, no integral, override on.
  task automatic out_of_box(input logic [31:0] kop, output logic bad);
    logic a0, e0;
    logic [31:0] q0;
    bad = 1'b0;
    access(1'b1, 10'h1AF, 32'h0000_0002, a0, e0, q0);
    bad |= e0 | !a0;
    access(1'b1, 10'h1B0, kop, a0, e0, q0);
    bad |= e0 | !a0;
    access(1'b1, 10'h1B1, 32'h0000_0000, a0, e0, q0);
    bad |= e0 | !a0;
    access(1'b1, 10'h041, 32'h0000_0001, a0, e0, q0);
    bad |= e0 | !a0;
  endtask
endmodule
`default_nettype wire

//--- tb/test_load_observer.sv
/* Self-checking bench for the load observer.
   Assumes the controller model and the port checker are compiled alongside. */
`timescale 1ns/1ps
`default_nettype none
`include "load_observer_regs.svh"
`define CHK(nm, ex, got) \
  begin \
    compares++; \
    if ((got) !== (ex)) begin \
      miscompares++; \
      $display("BAD %s expected %0h seen %0h", nm, ex, got); \
    end \
  end
module test_load_observer;
  import load_observer_pkg::*;
  logic clk = 1'b0, rst = 1'b1, update = 1'b0, a, e, wr, rd, ack, err, bad;
  logic signed [31:0] accel_ref = 0, pos_fdbk = 0, vel_fdbk = 0, accel_fwd, vel_out;
  logic [15:0] lpf_req = 16'h0000, lpf_act;
  logic [9:0] id;
  logic [31:0] wdata, rdata, q, d;
  logic signed [15:0] trq;
  logic trq_on, vel_on, bypass;
  obs_mode_type mode_act, prev;
  int miscompares = 0;
  int compares = 0;
  logic [15:0] reqs[8] = '{16'h0000, 16'h0001, 16'h0185, 16'h0186,
                           16'h28BE, 16'h28BF, 16'hFFFF, 16'h0000};
  logic [31:0] kops[4] = '{32'h0000_30D4, 32'h0000_30D5, 32'hFFFF_FFFF, 32'h0000_0000};

  always #25 clk = ~clk;
  load_observer dut (.CLK(clk), .RST(rst), .UPDATE(update), .ACCEL_REF(accel_ref),
    .POS_FDBK(pos_fdbk), .VEL_FDBK(vel_fdbk), .LPF_BW_REQ(lpf_req), .PARAM_WR(wr),
    .PARAM_RD(rd), .PARAM_ID(id), .PARAM_WDATA(wdata), .PARAM_RDATA(rdata),
    .PARAM_ACK(ack), .PARAM_ERR(err), .ACCEL_FWD(accel_fwd), .VEL_LOOP_FDBK(vel_out),
    .TORQUE_EST(trq), .TORQUE_EST_ACTIVE(trq_on), .VEL_EST_ACTIVE(vel_on),
    .LPF_BW_ACTUAL(lpf_act), .LPF_BYPASS(bypass), .MODE_ACTIVE(mode_act));
  load_observer_ctl ctl (.clk(clk), .ack(ack), .err(err), .rdata(rdata),
    .wr(wr), .rd(rd), .id(id), .wdata(wdata));

  // ==========================================================
  // Expectations and bus helpers
  function automatic logic [15:0] lpf_exp(input logic ovr, input logic [15:0] req);
    if (req == 16'h0000) return ovr ? 16'h0000 : `LPF_LEGACY_HZ;
    if (!ovr && req > `LPF_LEGACY_HZ) return `LPF_LEGACY_HZ;
    if (req > `LPF_OVERRIDE_HZ) return `LPF_OVERRIDE_HZ;
    return req;
  endfunction
  task automatic wr_par(input logic [9:0] pid, input logic [31:0] dv, input logic xe);
    ctl.access(1'b1, pid, dv, a, e, q);
    `CHK("write ack", 1'b1, a)
    `CHK("write refused", xe, e)
  endtask
  task automatic rd_par(input logic [9:0] pid, input logic [31:0] xq, input logic xe);
    ctl.access(1'b0, pid, 32'h0000_0000, a, e, q);
    `CHK("read ack", 1'b1, a)
    `CHK("read refused", xe, e)
    `CHK("read data", xq, q)
  endtask
  task automatic pulse(input int n);
    repeat (n) begin
      @(negedge clk);
      update = 1'b1;
      accel_ref = $urandom;
      vel_fdbk = $urandom;
      @(negedge clk);
      update = 1'b0;
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  initial begin
    void'($urandom(32'h0000_28DA));
    repeat (6) @(negedge clk);
    `CHK("reset mode", MODE_OFF, mode_act)
    `CHK("reset filter", `LPF_LEGACY_HZ, lpf_act)
    rst = 1'b0;
    rd_par(`PAR_MODE, 32'(`MODE_RESET), 1'b0);
    rd_par(`PAR_KOF, 32'(`KOF_RESET), 1'b0);
    rd_par(`PAR_BW_OVERRIDE, 32'(`OVERRIDE_RESET), 1'b0);
    d = $urandom;
    wr_par(`PAR_KOI, d, 1'b0);
    rd_par(`PAR_KOI, {16'h0000, d[15:0]}, 1'b0);
    kops[3] = $urandom_range(12500);
    foreach (kops[i]) begin
      wr_par(`PAR_KOP, kops[i], 1'b0);
      rd_par(`PAR_KOP, kops[i] > 12500 ? 32'(`KOP_MAX) : kops[i], 1'b0);
    end
    wr_par(`PAR_KOF, 32'h0000_0005, 1'b1);
    wr_par(`PAR_MODE, 32'h0000_0005, 1'b1);
    wr_par(`PAR_ACCEL_EST, d, 1'b1);
    wr_par(`PAR_TORQUE_EST, d, 1'b1);
    rd_par(10'h3FF, 32'h0000_0000, 1'b1);
    wr_par(`PAR_MODE, 32'h0000_0004, 1'b0);
    wr_par(`PAR_KOF, 32'h0000_01F4, 1'b0);
    rd_par(`PAR_KOF, 32'(`KOF_MAX), 1'b0);
    wr_par(`PAR_KOP, 32'h0000_03E8, 1'b0);
    prev = MODE_OFF;
    for (int m = 0; m < 5; m++) begin
      wr_par(`PAR_MODE, 32'(m), 1'b0);
      `CHK("mode before update", prev, mode_act)
      pulse(2);
      `CHK("mode in use", 3'(m), mode_act)
      `CHK("torque est on", m inside {1, 2, 4}, trq_on)
      `CHK("velocity est on", m inside {2, 3}, vel_on)
      if (m == 0) rd_par(`PAR_ACCEL_EST, 32'h0000_0000, 1'b0);
      ctl.access(1'b0, `PAR_TORQUE_EST, 32'h0000_0000, a, e, q);
      `CHK("torque readback", trq, q[15:0])
      if (!vel_on) `CHK("velocity passed", vel_fdbk, vel_out)
      prev = obs_mode_type'(m);
    end
    for (int m = 0; m < 3; m++) begin
      wr_par(`PAR_MODE, m == 1 ? 32'h0000_0004 : 32'(m), 1'b0);
      pulse(12);
      `CHK("estimate moved", m == 2, trq != 0)
    end
    // Mode zero tracks a position step, and mode three hands it to the velocity loop.
    wr_par(`PAR_MODE, 32'h0000_0000, 1'b0);
    pulse(2);
    wr_par(`PAR_MODE, 32'h0000_0003, 1'b0);
    d = $urandom;
    pos_fdbk = pos_fdbk + d;
    pulse(2);
    `CHK("velocity estimate", d, vel_out)
    for (int o = 0; o < 2; o++) begin
      wr_par(`PAR_BW_OVERRIDE, 32'(o), 1'b0);
      reqs[7] = 16'($urandom);
      foreach (reqs[i]) begin
        @(negedge clk);
        lpf_req = reqs[i];
        @(negedge clk);
        `CHK("filter bandwidth", lpf_exp(o[0], reqs[i]), lpf_act)
        `CHK("filter bypass", o[0] && reqs[i] == 16'h0000, bypass)
      end
    end
    // Filter request kept above five times the observer bandwidth.
    lpf_req = 16'h28BE;
    ctl.out_of_box(32'h0000_07A5, bad);
    `CHK("start-up set", 1'b0, bad)
    pulse(2);
    `CHK("start-up mode", MODE_TORQUE_VEL, mode_act)
    `CHK("start-up filter", `LPF_OVERRIDE_HZ, lpf_act)
    tally_and_finish();
  end
  initial begin
    #1000000;
    miscompares++;
    tally_and_finish();
  end
endmodule
bind load_observer load_observer_asserts #(.DW(DW)) chk (.*);
`default_nettype wire
